// [hpd_controller.sv]
// Purpose: host side controller driving a 1M x 16 hyper page DRAM over its pins
// Assumes: one 25 MHz clock; pin inputs synchronous; fast grade timing
// Notes:   early write only, so the device never drives data during writes
// What the document says about the device
// [RULE_01] Hold strobes high 200us, then eight row-only refreshes
// [RULE_02] Counter refresh needs eight column-before-row init cycles
// [RULE_03] Refresh every row within 16.4 ms
// [RULE_04] Early write keeps device outputs high-impedance
// [RULE_05] Late write strobe gives read-modify-write
// [RULE_06] Otherwise delayed write, outputs invalid
// [RULE_07] Write command leads row and column strobe rise
// [RULE_08] Read keeps write strobe high past strobe rise
// [RULE_09] Write data off bus until column strobe falls
// [RULE_10] Row access 60 ns within delay maximum
// [RULE_11] At least 14 ns row to column strobe
// [RULE_12] Row strobe low no longer than 100000 ns
// [RULE_13] Random cycles at least 104 ns apart
// [RULE_14] Page column cycles at least 25 ns apart
// [RULE_15] Column precharge at least 10 ns
// [RULE_16] Page access counts from column precharge
// [RULE_17] Refresh column strobe leads, holds 10 ns
// [RULE_18] Column-first refresh drives no column address
// [RULE_19] Row then column address on ten pins
// [RULE_20] Lower strobe low byte, upper strobe high byte
// [RULE_21] Write strobe low at column fall means write
// [RULE_22] Keep row open for same-row accesses
`timescale 1ns/10ps
`default_nettype none
module hpd_controller
	import hpd_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYC,
	parameter int REF_CYCLES     = REF_INTERVAL_CYC,
	parameter int RASP_CYCLES    = RASP_MAX_CYC
)
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              useCounterRefresh,
	input  wire logic              reqValid,
	input  wire hpd_req_t          req,
	output logic                   reqReady,
	output logic                   rdValid,
	output logic [DATA_W-1:0]      rdData,
	output logic                   initDone,
	output hpd_strobe_t            strobes,
	output logic [ADDR_W-1:0]      mux_address_pins,
	output logic [DATA_W-1:0]      dataPinsOut,
	output logic                   dataPinsOeN,
	input  wire logic [DATA_W-1:0] data_pins
);
	typedef enum {
		S_POWERUP, S_IDLE, S_RAS, S_CAS, S_CPRE, S_PRE, S_REF_RAS, S_REF_CAS, S_REF_CBR
	} hpd_state_t;

	hpd_state_t          state_q, state_d;
	logic [CNT_W-1:0]    cnt_q, cnt_d;
	logic [CNT_W-1:0]    refCnt_q, refCnt_d;
	logic [CNT_W-1:0]    rasCnt_q, rasCnt_d;
	logic [3:0]          initLeft_q, initLeft_d;
	logic                refPend_q, refPend_d;
	logic [ADDR_W-1:0]   refRow_q, refRow_d;
	logic [ADDR_W-1:0]   openRow_q, openRow_d;
	logic                rowOpen_q, rowOpen_d;
	logic                pendReq_q, pendReq_d;
	hpd_req_t            cur_q, cur_d;
	hpd_strobe_t         stb_q, stb_d;
	logic [ADDR_W-1:0]   addr_q, addr_d;
	logic [DATA_W-1:0]   dout_q, dout_d;
	logic                oeN_q, oeN_d;
	logic                ready_q, ready_d;
	logic                rdValid_q, rdValid_d;
	logic [DATA_W-1:0]   rdData_q, rdData_d;
	logic                initDone_q, initDone_d;
	logic                sameRow;

	localparam hpd_strobe_t STB_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

	assign sameRow = rowOpen_q && (req.row == openRow_q);

	always_comb
	begin
		state_d    = state_q;
		cnt_d      = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
		refCnt_d   = (refCnt_q != '0) ? refCnt_q - 1'b1 : refCnt_q;
		rasCnt_d   = rowOpen_q ? rasCnt_q + 1'b1 : '0;
		initLeft_d = initLeft_q;
		refPend_d  = refPend_q || (refCnt_q == '0 && initDone_q);
		refRow_d   = refRow_q;
		openRow_d  = openRow_q;
		rowOpen_d  = rowOpen_q;
		pendReq_d  = pendReq_q;
		cur_d      = cur_q;
		stb_d      = stb_q;
		addr_d     = addr_q;
		dout_d     = dout_q;
		oeN_d      = oeN_q;
		ready_d    = 1'b0;
		rdValid_d  = 1'b0;
		rdData_d   = rdData_q;
		initDone_d = initDone_q;
		if (refCnt_q == '0)
			refCnt_d = CNT_W'(REF_CYCLES); // RULE_03
		case (state_q)
			S_POWERUP:
			begin
				stb_d = STB_IDLE; // RULE_01
				if (cnt_q == '0)
				begin
					state_d = S_PRE;
					cnt_d   = CNT_W'(RP_CYC);
				end
			end
			S_IDLE:
			begin
				// Drop ready a cycle early when refresh is due, so a request seen as taken always is
				ready_d = initDone_q && !refPend_d && !reqValid;
				if (initLeft_q != '0 || refPend_q)
				begin
					if (rowOpen_q)
					begin
						state_d = S_PRE;
						cnt_d   = CNT_W'(RP_CYC);
					end
					else if (useCounterRefresh)
					begin
						stb_d.lowerColStrobeN = 1'b0; // RULE_17 RULE_18
						stb_d.upperColStrobeN = 1'b0;
						state_d = S_REF_CAS;
						cnt_d   = '0;
					end
					else
					begin
						addr_d  = refRow_q; // RULE_01 RULE_19
						state_d = S_REF_RAS;
						cnt_d   = CNT_W'(RC_CYC - RP_CYC);
					end
				end
				else if (reqValid && initDone_q && ready_q)
				begin
					cur_d = req;
					if (rowOpen_q && sameRow && rasCnt_q < CNT_W'(RASP_CYCLES - 16))
					begin
						addr_d  = req.col; // RULE_22
						state_d = S_CAS;
						stb_d.writeStrobeN = !req.write; // RULE_07 RULE_21 RULE_04
						stb_d.outGateN     = req.write;
						dout_d  = req.wdata;
						cnt_d   = CNT_W'(CAS_CYC);
					end
					else if (rowOpen_q)
					begin
						pendReq_d = 1'b1;
						state_d = S_PRE;
						cnt_d   = CNT_W'(RP_CYC);
					end
					else
					begin
						addr_d  = req.row; // RULE_19
						state_d = S_RAS;
						cnt_d   = CNT_W'(RCD_CYC);
					end
				end
				else if (rowOpen_q && rasCnt_q >= CNT_W'(RASP_CYCLES - 16))
				begin
					ready_d = 1'b0;
					state_d = S_PRE; // RULE_12
					cnt_d   = CNT_W'(RP_CYC);
				end
			end
			S_RAS:
			begin
				stb_d.rowStrobeN = 1'b0;
				rowOpen_d = 1'b1;
				openRow_d = cur_q.row;
				if (cnt_q == '0 && !stb_q.rowStrobeN)
				begin
					addr_d  = cur_q.col; // RULE_11 RULE_19
					stb_d.writeStrobeN = !cur_q.write; // RULE_07 RULE_04
					stb_d.outGateN     = cur_q.write;
					dout_d  = cur_q.wdata;
					state_d = S_CAS;
					cnt_d   = CNT_W'(RAC_CYC); // RULE_10
				end
			end
			S_CAS:
			begin
				// Column falls in the same cycle the write data is driven onto the bus; bus released by the device
				stb_d.lowerColStrobeN = !cur_q.laneEn[0]; // RULE_20
				stb_d.upperColStrobeN = !cur_q.laneEn[1];
				oeN_d = !cur_q.write; // RULE_09
				if (cnt_q == '0 && (!stb_q.lowerColStrobeN || !stb_q.upperColStrobeN))
				begin
					if (!cur_q.write)
					begin
						rdValid_d = 1'b1;
						rdData_d  = data_pins;
					end
					stb_d = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1}; // RULE_08 RULE_15
					oeN_d = 1'b1;
					state_d = S_CPRE;
					cnt_d   = CNT_W'(CP_CYC);
				end
			end
			S_CPRE:
			begin
				// Precharge before the next column keeps page cycle above minimum
				if (cnt_q == '0)
					state_d = S_IDLE; // RULE_14 RULE_16
			end
			S_PRE:
			begin
				stb_d = STB_IDLE; // RULE_13
				rowOpen_d = 1'b0;
				if (cnt_q == '0 && pendReq_q)
				begin
					// A taken request for another row opens it right after precharge
					addr_d    = cur_q.row; // RULE_19
					pendReq_d = 1'b0;
					state_d   = S_RAS;
					cnt_d     = CNT_W'(RCD_CYC);
				end
				else if (cnt_q == '0)
				begin
					state_d = S_IDLE;
					if (!initDone_q && initLeft_q == '0)
						initLeft_d = 4'(INIT_REFRESHES); // RULE_01 RULE_02
				end
			end
			S_REF_RAS:
			begin
				stb_d.rowStrobeN = 1'b0;
				if (cnt_q == '0)
				begin
					refRow_d = refRow_q + 1'b1;
					state_d  = S_REF_CBR;
				end
			end
			S_REF_CAS:
			begin
				stb_d.rowStrobeN = 1'b0; // RULE_17
				state_d = S_REF_RAS;
				cnt_d   = CNT_W'(CHR_CYC + RSH_CYC);
			end
			S_REF_CBR:
			begin
				stb_d = STB_IDLE;
				// An interval ending in this very cycle stays pending
				refPend_d = initDone_q && (refCnt_q == '0); // RULE_03
				if (initLeft_q != '0)
				begin
					initLeft_d = initLeft_q - 1'b1;
					if (initLeft_q == 4'h1)
						initDone_d = 1'b1;
				end
				state_d = S_PRE;
				cnt_d   = CNT_W'(RP_CYC);
			end
			default:
				state_d = S_PRE;
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_q    <= S_POWERUP;
			cnt_q      <= CNT_W'(POWERUP_CYCLES);
			refCnt_q   <= CNT_W'(REF_CYCLES);
			rasCnt_q   <= '0;
			initLeft_q <= '0;
			refPend_q  <= 1'b0;
			refRow_q   <= '0;
			openRow_q  <= '0;
			rowOpen_q  <= 1'b0;
			pendReq_q  <= 1'b0;
			cur_q      <= '0;
			stb_q      <= STB_IDLE;
			addr_q     <= '0;
			dout_q     <= '0;
			oeN_q      <= 1'b1;
			ready_q    <= 1'b0;
			rdValid_q  <= 1'b0;
			rdData_q   <= '0;
			initDone_q <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			refCnt_q   <= refCnt_d;
			rasCnt_q   <= rasCnt_d;
			initLeft_q <= initLeft_d;
			refPend_q  <= refPend_d;
			refRow_q   <= refRow_d;
			openRow_q  <= openRow_d;
			rowOpen_q  <= rowOpen_d;
			pendReq_q  <= pendReq_d;
			cur_q      <= cur_d;
			stb_q      <= stb_d;
			addr_q     <= addr_d;
			dout_q     <= dout_d;
			oeN_q      <= oeN_d;
			ready_q    <= ready_d;
			rdValid_q  <= rdValid_d;
			rdData_q   <= rdData_d;
			initDone_q <= initDone_d;
		end
	end

	assign reqReady         = ready_q;
	assign rdValid          = rdValid_q;
	assign rdData           = rdData_q;
	assign initDone         = initDone_q;
	assign strobes          = stb_q;
	assign mux_address_pins = addr_q;
	assign dataPinsOut      = dout_q;
	assign dataPinsOeN      = oeN_q;
endmodule // hpd_controller
`default_nettype wire

// [hpd_controller_chk.sv]
// Purpose: port-level timing checks for the DRAM controller
// Assumes: one clock domain, async active-high reset
// Notes:   counters stand in for windows too long to unroll
`timescale 1ns/10ps
`default_nettype none
module hpd_controller_chk
	import hpd_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYC,
	parameter int RASP_CYCLES    = RASP_MAX_CYC
)
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        initDone,
	input wire hpd_strobe_t strobes,
	input wire logic        dataPinsOeN
);
	logic [CNT_W-1:0] upCnt_q, upCnt_d, lowCnt_q, lowCnt_d;
	logic [3:0]       refCnt_q, refCnt_d;
	logic             rowN_q;
	wire logic        colsUp = strobes.lowerColStrobeN && strobes.upperColStrobeN;
	always_comb
	begin
		upCnt_d = (upCnt_q == '1) ? upCnt_q : upCnt_q + 1'b1;
		lowCnt_d = strobes.rowStrobeN ? '0 : lowCnt_q + 1'b1;
		refCnt_d = (rowN_q && !strobes.rowStrobeN && refCnt_q != 4'hF) ? refCnt_q + 1'b1 : refCnt_q;
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			upCnt_q <= '0;
			lowCnt_q <= '0;
			refCnt_q <= '0;
			rowN_q <= 1'b1;
		end
		else
		begin
			upCnt_q <= upCnt_d;
			lowCnt_q <= lowCnt_d;
			refCnt_q <= refCnt_d;
			rowN_q <= strobes.rowStrobeN;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence rowOpen;
		$fell(strobes.rowStrobeN);
	endsequence
	sequence cbrStart;
		$fell(strobes.rowStrobeN) && !colsUp;
	endsequence
	a_pause_first: assert property (rowOpen |-> upCnt_q >= POWERUP_CYCLES)
		else $error("row strobe fell before the power-up pause ended");
	a_init_count: assert property ($rose(initDone) |-> refCnt_q >= 4'h8)
		else $error("init done after fewer than eight refresh cycles");
	a_rcd_min: assert property ($fell(strobes.rowStrobeN) && $past(colsUp) |-> colsUp)
		else $error("column strobe fell together with row strobe");
	a_cbr_hold: assert property (cbrStart |=> !strobes.lowerColStrobeN && !strobes.upperColStrobeN)
		else $error("column strobes released too early in column-first refresh");
	a_read_we_hold: assert property ($rose(strobes.lowerColStrobeN) && $past(strobes.writeStrobeN)
		|-> strobes.writeStrobeN)
		else $error("write strobe dropped at end of read");
	a_rc_spacing: assert property (rowOpen |=> !$fell(strobes.rowStrobeN) [*2])
		else $error("row cycles closer than three clocks");
	a_ras_max: assert property (lowCnt_q < RASP_CYCLES)
		else $error("row strobe held low too long");
	a_oe_gate: assert property (!dataPinsOeN |-> strobes.outGateN && !strobes.writeStrobeN)
		else $error("controller drives data while device output may be on");
endmodule // hpd_controller_chk
`default_nettype wire

// [hpd_controller_test.sv]
// Purpose: self-checking bench for the DRAM controller
// Assumes: shortened power-up, refresh and row-open counts
// Notes:   both refresh modes run; memory persists across resets
`timescale 1ns/10ps
`default_nettype none
module hpd_controller_test
	import hpd_pkg::*;
;
	localparam int PU = 20;
	localparam int RF = 200;
	localparam int RP = 64;
	logic clock, rst, useCounterRefresh, reqValid, reqReady, rdValid, initDone, dataPinsOeN;
	hpd_req_t          req;
	hpd_strobe_t       strobes;
	logic [DATA_W-1:0] rdData, dataPinsOut, modelDq;
	logic [ADDR_W-1:0] mux_address_pins;
	wire logic [DATA_W-1:0] dataBus = dataPinsOeN ? modelDq : dataPinsOut;
	logic [DATA_W-1:0] shadow [int];
	int err_total, n_checks, cyc, falls, f0, i, m, k;
	hpd_controller #(.POWERUP_CYCLES(PU), .REF_CYCLES(RF), .RASP_CYCLES(RP)) hpd_controller_i (.clock(clock),
		.rst(rst), .useCounterRefresh(useCounterRefresh), .reqValid(reqValid), .req(req), .reqReady(reqReady),
		.rdValid(rdValid), .rdData(rdData), .initDone(initDone), .strobes(strobes),
		.mux_address_pins(mux_address_pins), .dataPinsOut(dataPinsOut), .dataPinsOeN(dataPinsOeN),
		.data_pins(dataBus));
	hpd_dram_model hpd_dram_model_i (.strobes(strobes), .mux_address_pins(mux_address_pins), .dataBus(dataBus),
		.dq(modelDq));
	always #20 clock = ~clock;
	always @(negedge strobes.rowStrobeN) falls++;
	task automatic final_report;
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			final_report();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] ln);
		return {ln[1] ? nw[15:8] : old[15:8], ln[0] ? nw[7:0] : old[7:0]};
	endfunction
	task automatic op(input logic w, input logic [1:0] ln, input logic [9:0] r, input logic [9:0] c,
		input logic [15:0] d);
		int n, key;
		logic taken;
		logic [15:0] mask;
		n = 0;
		taken = 1'b0;
		key = int'({r, c});
		mask = {{8{ln[1]}}, {8{ln[0]}}};
		while (!taken && n < 600)
		begin
			@(posedge clock);
			n++;
			if (reqReady === 1'b1)
			begin
				reqValid <= 1'b1;
				req <= '{w, ln, r, c, d};
				@(posedge clock);
				taken = (reqReady === 1'b1);
				reqValid <= 1'b0;
			end
		end
		if (!taken) err_total++;
		if (w)
			shadow[key] = merge(shadow.exists(key) ? shadow[key] : '0, d, ln);
		else
		begin
			n = 0;
			do
			begin
				@(posedge clock);
				n++;
			end
			while (rdValid !== 1'b1 && n < 200);
			if (rdValid !== 1'b1) err_total++;
			// Lanes whose strobe stayed high carry no data
			check(rdData & mask, (shadow.exists(key) ? shadow[key] : 16'h0000) & mask);
		end
	endtask
	initial
	begin
		clock = 1'b0;
		rst = 1'b1;
		useCounterRefresh = 1'b0;
		reqValid = 1'b0;
		req = '0;
		err_total = 0;
		n_checks = 0;
		cyc = 0;
		falls = 0;
		void'($urandom(32'h5D53));
		for (m = 0; m < 2; m++)
		begin
			rst <= 1'b1;
			useCounterRefresh <= m[0];
			repeat (12) @(posedge clock);
			check(16'(strobes), 16'h001F);
			check(16'(initDone), 16'h0000);
			rst <= 1'b0;
			k = 0;
			while (initDone !== 1'b1 && k < 2000)
			begin
				@(posedge clock);
				k++;
			end
			check(16'(initDone), 16'h0001);
			op(1'b1, 2'b11, 10'h3FF, 10'h3FF, 16'hFFFF);
			op(1'b1, 2'b01, 10'h3FF, 10'h3FF, 16'h1200);
			op(1'b0, 2'b11, 10'h3FF, 10'h3FF, 16'h0000);
			op(1'b1, 2'b10, 10'h000, 10'h000, 16'hAB34);
			op(1'b0, 2'b11, 10'h000, 10'h000, 16'h0000);
			for (i = 0; i < 40; i++)
				op(1'(($urandom % 2)), 2'(($urandom % 3) + 1), 10'(($urandom % 3) * 341), 10'($urandom % 8),
					16'($urandom));
			f0 = falls;
			repeat (3 * RF) @(posedge clock);
			check(16'(falls - f0 >= 2), 16'h0001);
			op(1'b0, 2'b11, 10'h3FF, 10'h3FF, 16'h0000);
		end
		final_report();
	end
endmodule // hpd_controller_test
bind hpd_controller hpd_controller_chk #(.POWERUP_CYCLES(POWERUP_CYCLES), .RASP_CYCLES(RASP_CYCLES))
	hpd_controller_chk_i (.clock(clock), .rst(rst), .initDone(initDone), .strobes(strobes),
	.dataPinsOeN(dataPinsOeN));
`default_nettype wire

// [hpd_dram_model.sv]
// Purpose: behavioural 1M x 16 page-mode DRAM for the controller bench
// Assumes: controller issues early writes only
// Notes:   released data lines show the inverse of the last word
`timescale 1ns/10ps
`default_nettype none
module hpd_dram_model
	import hpd_pkg::*;
(
	input  wire hpd_strobe_t       strobes,
	input  wire logic [ADDR_W-1:0] mux_address_pins,
	input  wire logic [DATA_W-1:0] dataBus,
	output logic [DATA_W-1:0]      dq
);
	logic [DATA_W-1:0] mem [int];
	logic [ADDR_W-1:0] rowQ, colQ;
	logic [DATA_W-1:0] rdWord, held = 16'hA5A5;
	int                wrCnt = 0;
	wire logic rd = !strobes.rowStrobeN && strobes.writeStrobeN && !strobes.outGateN;
	wire logic loOn = rd && !strobes.lowerColStrobeN;
	wire logic upOn = rd && !strobes.upperColStrobeN;
	task automatic wr(input logic [1:0] ln);
		logic [DATA_W-1:0] w;
		w = mem.exists(int'({rowQ, colQ})) ? mem[int'({rowQ, colQ})] : '0;
		if (ln[0]) w[7:0] = dataBus[7:0];
		if (ln[1]) w[15:8] = dataBus[15:8];
		mem[int'({rowQ, colQ})] = w;
		wrCnt++;
	endtask
	always @(negedge strobes.rowStrobeN)
		if (strobes.lowerColStrobeN && strobes.upperColStrobeN) rowQ = mux_address_pins;
	always @(negedge strobes.lowerColStrobeN)
		if (!strobes.rowStrobeN)
		begin
			colQ = mux_address_pins;
			// Write data reaches the bus in the same step as the strobe falls
			if (!strobes.writeStrobeN) #1 wr(2'b01);
		end
	always @(negedge strobes.upperColStrobeN)
		if (!strobes.rowStrobeN)
		begin
			colQ = mux_address_pins;
			if (!strobes.writeStrobeN) #1 wr(2'b10);
		end
	always @(rowQ, colQ, wrCnt)
		rdWord = mem.exists(int'({rowQ, colQ})) ? mem[int'({rowQ, colQ})] : '0;
	always @(negedge rd) held = ~rdWord;
	// Access well inside one clock so the slowest legal sample still sees it
	assign #15 dq = {upOn ? rdWord[15:8] : held[15:8], loOn ? rdWord[7:0] : held[7:0]};
endmodule // hpd_dram_model
`default_nettype wire

// [hpd_pkg.sv]
// Purpose: constants and carriers for the hyper page DRAM controller
// Assumes: 25 MHz clock, fast speed grade timings, standard power refresh
// Notes:   times are kept in their own unit, cycle counts derive from them
package hpd_pkg;
	localparam int CLK_MHZ = 25;
	localparam int CLK_NS = 1000 / CLK_MHZ;
	localparam int POWERUP_US = 200;
	localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
	localparam int INIT_REFRESHES = 8;
	localparam int REFRESH_ROWS = 1024;
	localparam int REF_PERIOD_US = 16400;
	localparam int REF_INTERVAL_CYC = (REF_PERIOD_US * CLK_MHZ) / REFRESH_ROWS;
	localparam int RC_NS = 104;
	localparam int RAS_PRE_NS = 40;
	localparam int RCD_MIN_NS = 14;
	localparam int RAC_NS = 60;
	localparam int CAS_PULSE_NS = 10;
	localparam int CP_NS = 10;
	localparam int CPA_NS = 35;
	localparam int RSH_NS = 15;
	localparam int CHR_NS = 10;
	localparam int RASP_MAX_NS = 100000;
	localparam int RP_CYC = (RAS_PRE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RCD_CYC = (RCD_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAS_CYC = (CAS_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CP_CYC = (CP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAC_CYC = (RAC_NS + CLK_NS - 1) / CLK_NS;
	localparam int CPA_CYC = (CPA_NS + CLK_NS - 1) / CLK_NS;
	localparam int RSH_CYC = (RSH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CHR_CYC = (CHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int RC_CYC = (RC_NS + CLK_NS - 1) / CLK_NS;
	localparam int RASP_MAX_CYC = RASP_MAX_NS / CLK_NS;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int CNT_W = 18;

	typedef struct packed {
		logic                  write;
		logic [1:0]            laneEn;
		logic [ADDR_W-1:0]     row;
		logic [ADDR_W-1:0]     col;
		logic [DATA_W-1:0]     wdata;
	} hpd_req_t;

	typedef struct packed {
		logic                  rowStrobeN;
		logic                  lowerColStrobeN;
		logic                  upperColStrobeN;
		logic                  writeStrobeN;
		logic                  outGateN;
	} hpd_strobe_t;
endpackage : hpd_pkg
